// ===== hw/cpc_pkg.sv
// copper control register package: field layout, reset values, mdio framing
// assumes a clause-22 style management frame and a page select held elsewhere
package cpc_pkg;

  // --------------------------------------------------------------
  // management addressing
  // --------------------------------------------------------------
  localparam logic [4:0] PHY_ADDR     = 5'h01;
  localparam logic [4:0] REG_CTRL1    = 5'h10;
  localparam logic [7:0] PAGE_COPPER  = 8'h00;
  localparam logic [1:0] ST_CODE      = 2'h1;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [4:0] HDR_LAST     = 5'h0d;
  localparam logic [4:0] DATA_LAST    = 5'h0f;

  // --------------------------------------------------------------
  // register layout and reset values
  // --------------------------------------------------------------
  localparam int          BIT_RSVD     = 4;
  localparam logic [15:0] CTRL_HW_RST  = 16'h3060;
  localparam logic [2:0]  DS_COUNT_RST = 3'h3;
  localparam logic [1:0]  XOVER_RST    = 2'h3;
  localparam logic [1:0]  ED_OFF       = 2'h0;

  // crossover mode encodings
  localparam logic [1:0]  XOVER_MDI    = 2'h0;
  localparam logic [1:0]  XOVER_MDIX   = 2'h1;
  localparam logic [1:0]  XOVER_AUTO   = 2'h3;

  // resolved speed encodings
  localparam logic [1:0]  SPD_10       = 2'h0;
  localparam logic [1:0]  SPD_1000     = 2'h2;

  // bit order matches the register word, msb first
  typedef struct packed {
    logic       link_pulse_off;
    logic [2:0] ds_count;
    logic       ds_en;
    logic       force_link;
    logic [1:0] ed_mode;
    logic       ext_dist;
    logic [1:0] xover;
    logic       rsvd;
    logic       tx_off;
    logic       pwr_dn;
    logic       pol_dis;
    logic       jab_dis;
  } cpc_ctrl_t;

  // fields that only take hold on a software reset
  typedef struct packed {
    logic [2:0] ds_count;
    logic       ds_en;
    logic [1:0] ed_mode;
    logic [1:0] xover;
  } cpc_active_t;

  typedef struct packed {
    logic       link_pulse_off;
    logic [2:0] ds_count;
    logic       ds_en;
    logic       force_link_up;
    logic [1:0] ed_mode;
    logic       ext_dist;
    logic [1:0] xover;
    logic       tx_off;
    logic       power_down;
    logic       gmii_off;
    logic       pol_fixed;
    logic       jabber_en;
  } cpc_phy_ctl_t;

  typedef enum logic [1:0] {
    MD_IDLE = 2'b00,
    MD_HDR  = 2'b01,
    MD_TA   = 2'b10,
    MD_DATA = 2'b11
  } cpc_fsm_t;

endpackage

// ===== hw/cpc_copper_ctrl.sv
// copper specific control register with its management frame slave
// assumes mdc and mdio_i are synchronous to mclk and mdc is much slower;
// the page select, basic control bits and resolved speed come from the phy core
//
// Operation
// - register answers at phy address 01, register 16, page 0 only.
// - bit 15 stops link pulses; cleared by hardware and software reset.
// - bits 14:12 give gigabit attempts minus one; reset value 3.
// - bit 11 enables downshift; hardware reset clears it.
// - downshift fields act only after the next software reset.
// - bit 10 forces link up, except at gigabit speed.
// - bits 9:8 select energy sense mode; strap loads them after hardware reset.
// - bit 7 lowers the 10 Mb/s receive threshold.
// - bits 6:5 pick mdi, mdix or automatic crossover; reset value 3.
// - crossover mode acts only after the next software reset.
// - bit 3 disables the copper transmitter.
// - power down is bit 2 or basic control power down bit.
// - leaving power down triggers software reset and negotiation restart.
// - during power down gmii stays alive only if keep alive is set.
// - bit 1 disables polarity correction, forcing normal polarity.
// - bit 0 disables jabber; jabber acts only in 10 Mb/s half duplex.
module cpc_copper_ctrl
  import cpc_pkg::*;
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // management serial port
  input  wire logic         mdc,
  input  wire logic         mdio_i,
  output logic              mdio_o,
  output logic              mdio_oe,
  // from the phy core
  input  wire logic [7:0]   page_sel,
  input  wire logic         sw_reset_req,
  input  wire logic         basic_power_down,
  input  wire logic         gmii_keep_alive,
  input  wire logic [1:0]   energy_sense_strap_value,
  input  wire logic [1:0]   speed,
  input  wire logic         full_duplex,
  // to the phy core
  output cpc_phy_ctl_t      phy_ctl,
  output logic              auto_sw_reset,
  output logic              auto_restart_an
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    cpc_ctrl_t   ctrl;
    cpc_active_t act;
    logic        strap_done;
    logic        pd_q;
    logic        auto_rst;
    logic        mdc_q;
    cpc_fsm_t    fsm;
    logic [5:0]  pre_cnt;
    logic [4:0]  bit_cnt;
    logic [15:0] shreg;
    logic        hdr_rd;
    logic        hdr_hit;
    logic        mdio_o;
    logic        mdio_oe;
  } cpc_state_t;

  cpc_state_t  s;
  cpc_state_t  next_s;
  logic        mdc_rise;
  logic        pd_now;
  logic        pd_exit;
  logic        sw_rst;
  logic        wr_commit;
  logic [13:0] hdr;
  logic [15:0] wr_word;

  assign mdc_rise  = mdc & ~s.mdc_q;
  assign hdr       = {s.shreg[12:0], mdio_i};
  assign wr_word   = {s.shreg[14:0], mdio_i};
  assign pd_now    = s.ctrl.pwr_dn | basic_power_down;
  assign pd_exit   = s.pd_q & ~pd_now;
  assign sw_rst    = sw_reset_req | pd_exit;
  assign wr_commit = mdc_rise && s.fsm == MD_DATA && !s.hdr_rd && s.hdr_hit &&
                     s.bit_cnt == DATA_LAST;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s       = s;
    next_s.mdc_q = mdc;
    next_s.pd_q  = pd_now;
    next_s.auto_rst = pd_exit;

    // frame slave, advanced on each rising mdc
    if (mdc_rise) begin
      case (s.fsm)
        MD_IDLE: begin
          if (mdio_i) begin
            if (s.pre_cnt != PREAMBLE_LEN) begin
              next_s.pre_cnt = s.pre_cnt + 6'h01;
            end
          end else if (s.pre_cnt == PREAMBLE_LEN) begin
            next_s.fsm     = MD_HDR;
            next_s.shreg   = 16'h0000;
            next_s.bit_cnt = 5'h01;
          end else begin
            next_s.pre_cnt = 6'h00;
          end
        end
        MD_HDR: begin
          next_s.shreg   = wr_word;
          next_s.bit_cnt = s.bit_cnt + 5'h01;
          if (s.bit_cnt == HDR_LAST) begin
            next_s.bit_cnt = 5'h00;
            next_s.pre_cnt = 6'h00;
            next_s.hdr_rd  = hdr[11:10] == OP_READ;
            next_s.hdr_hit = hdr[13:12] == ST_CODE &&
                             (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE) &&
                             hdr[9:5] == PHY_ADDR && hdr[4:0] == REG_CTRL1 &&
                             page_sel == PAGE_COPPER;
            next_s.fsm     = MD_TA;
            next_s.shreg   = s.ctrl;
          end
        end
        MD_TA: begin
          if (s.bit_cnt == 5'h00) begin
            next_s.bit_cnt = 5'h01;
            if (s.hdr_rd && s.hdr_hit) begin
              next_s.mdio_oe = 1'b1;
              next_s.mdio_o  = 1'b0;
            end
          end else begin
            next_s.bit_cnt = 5'h00;
            next_s.fsm     = MD_DATA;
            if (s.hdr_rd && s.hdr_hit) begin
              next_s.mdio_o = s.shreg[15];
              next_s.shreg  = {s.shreg[14:0], 1'b0};
            end
          end
        end
        MD_DATA: begin
          next_s.bit_cnt = s.bit_cnt + 5'h01;
          if (s.hdr_rd) begin
            next_s.mdio_o = s.shreg[15];
            next_s.shreg  = {s.shreg[14:0], 1'b0};
          end else begin
            next_s.shreg  = wr_word;
          end
          if (s.bit_cnt == DATA_LAST) begin
            next_s.fsm     = MD_IDLE;
            next_s.mdio_oe = 1'b0;
            next_s.mdio_o  = 1'b0;
            next_s.bit_cnt = 5'h00;
          end
        end
        default: begin
          next_s.fsm = MD_IDLE;
        end
      endcase
    end

    // stored as written, software keeps bit 4 at zero
    if (wr_commit) begin
      next_s.ctrl = wr_word;
    end

    // strap caught once after reset release
    if (!s.strap_done) begin
      next_s.strap_done   = 1'b1;
      next_s.ctrl.ed_mode = energy_sense_strap_value;
      next_s.act.ed_mode  = energy_sense_strap_value;
    end

    if (sw_rst) begin
      // link pulse disable clears on software reset
      next_s.ctrl.link_pulse_off = 1'b0;
      next_s.act.ds_count = next_s.ctrl.ds_count;
      next_s.act.ds_en    = next_s.ctrl.ds_en;
      next_s.act.ed_mode  = next_s.ctrl.ed_mode;
      next_s.act.xover    = next_s.ctrl.xover;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s            <= '0;
      s.ctrl       <= CTRL_HW_RST;
      s.act        <= {DS_COUNT_RST, 1'b0, ED_OFF, XOVER_RST};
      s.fsm        <= MD_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign mdio_o          = s.mdio_o;
  assign mdio_oe         = s.mdio_oe;
  assign auto_sw_reset   = s.auto_rst;
  assign auto_restart_an = s.auto_rst;

  always_comb begin
    phy_ctl                = '0;
    phy_ctl.link_pulse_off = s.ctrl.link_pulse_off;
    phy_ctl.ds_en          = s.act.ds_en;
    phy_ctl.ds_count       = s.act.ds_count;
    phy_ctl.force_link_up  = s.ctrl.force_link && speed != SPD_1000;
    phy_ctl.ed_mode        = s.act.ed_mode;
    phy_ctl.ext_dist       = s.ctrl.ext_dist;
    phy_ctl.xover          = s.act.xover;
    phy_ctl.tx_off         = s.ctrl.tx_off;
    phy_ctl.power_down     = pd_now;
    // gmii shut down in power down unless kept alive
    phy_ctl.gmii_off       = pd_now && !gmii_keep_alive;
    phy_ctl.pol_fixed      = s.ctrl.pol_dis;
    // jabber only in 10 Mb/s half duplex
    phy_ctl.jabber_en      = !s.ctrl.jab_dis && speed == SPD_10 && !full_duplex;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence read_hit_ta0;
    mdc_rise && s.fsm == MD_TA && s.bit_cnt == 5'h00 && s.hdr_rd && s.hdr_hit;
  endsequence

  sequence pd_fall;
    pd_now ##1 !pd_now;
  endsequence

  sequence read_hit_ta1;
    mdc_rise && s.fsm == MD_TA && s.bit_cnt == 5'h01 && s.hdr_rd && s.hdr_hit;
  endsequence

  sequence read_shift_rise;
    mdc_rise && s.fsm == MD_DATA && s.hdr_rd && s.bit_cnt != DATA_LAST;
  endsequence

  sequence data_last_rise;
    mdc_rise && s.fsm == MD_DATA && s.bit_cnt == DATA_LAST;
  endsequence

  sequence refused_ta0;
    mdc_rise && s.fsm == MD_TA && s.bit_cnt == 5'h00 && !(s.hdr_rd && s.hdr_hit);
  endsequence

  AST_WRITE_HIT: assert property (
    wr_commit && !sw_rst && s.strap_done |=> s.ctrl == $past(wr_word))
    else $error("register write at own address not stored");

  AST_WRITE_MISS: assert property (
    !wr_commit && !sw_rst && s.strap_done |=> $stable(s.ctrl))
    else $error("register changed without a matching write");

  AST_READ_TA: assert property (
    read_hit_ta0 |=> mdio_oe && !mdio_o)
    else $error("read turnaround not driven low");

  AST_LP_CLEAR: assert property (
    sw_rst |=> !s.ctrl.link_pulse_off)
    else $error("link pulse disable survived software reset");

  AST_DS_HOLD: assert property (
    !sw_rst && s.strap_done |=> $stable(s.act.ds_count) && $stable(s.act.ds_en))
    else $error("downshift setting applied without software reset");

  AST_DS_APPLY: assert property (
    sw_rst |=> s.act.ds_count == s.ctrl.ds_count && s.act.xover == s.ctrl.xover)
    else $error("pending fields not copied on software reset");

  AST_XOVER_HOLD: assert property (
    !sw_rst |=> $stable(s.act.xover))
    else $error("crossover mode applied without software reset");

  AST_FORCE_GIG: assert property (
    speed == SPD_1000 |-> !phy_ctl.force_link_up)
    else $error("forced link active at gigabit");

  AST_STRAP: assert property (
    !s.strap_done |=> s.ctrl.ed_mode == $past(energy_sense_strap_value))
    else $error("energy sense strap not loaded");

  AST_PD_EXIT: assert property (
    pd_fall |=> auto_sw_reset && auto_restart_an ##1 !auto_sw_reset)
    else $error("power down exit did not pulse reset and restart");

  AST_GMII: assert property (
    !pd_now |-> !phy_ctl.gmii_off && !phy_ctl.power_down)
    else $error("gmii off outside power down");

  AST_JABBER: assert property (
    speed != SPD_10 || full_duplex |-> !phy_ctl.jabber_en)
    else $error("jabber active outside 10 Mb/s half duplex");

  AST_READ_MSB: assert property (
    read_hit_ta1 |=> mdio_oe && mdio_o == $past(s.shreg[15]))
    else $error("read data msb not driven after turnaround");

  AST_READ_SHIFT: assert property (
    read_shift_rise |=> mdio_o == $past(s.shreg[15]))
    else $error("read data bit out of order");

  AST_READ_END: assert property (
    data_last_rise |=> !mdio_oe)
    else $error("mdio still driven after the last data bit");

  AST_REFUSE_QUIET: assert property (
    refused_ta0 |=> !mdio_oe)
    else $error("mdio driven for a frame not addressed here");

  AST_IDLE_QUIET: assert property (
    s.fsm == MD_IDLE |-> !mdio_oe)
    else $error("mdio driven outside a read frame");

  AST_RETAIN: assert property (
    sw_rst && !wr_commit && s.strap_done |=> s.ctrl[14:0] == $past(s.ctrl[14:0]))
    else $error("retained field changed on software reset");

  AST_PD_APPLY: assert property (
    pd_exit |=> auto_restart_an && s.act.ds_en == s.ctrl.ds_en)
    else $error("power down exit did not apply pending fields");

  AST_STRAP_ACT: assert property (
    !s.strap_done |=> s.act.ed_mode == $past(energy_sense_strap_value))
    else $error("energy sense strap not applied");

  AST_ED_HOLD: assert property (
    !sw_rst && s.strap_done |=> $stable(s.act.ed_mode))
    else $error("energy sense mode applied without software reset");

endmodule

// ===== sim/cpc_mdio_host.sv
// management station model: frames reads and writes on the mdio pins
// assumes the bench resolves the shared mdio wire with a pull-up
module cpc_mdio_host
  import cpc_pkg::*;
(
  // clock
  input  wire logic mclk,
  // mdio pins
  input  wire logic mdio_wire,
  output logic      mdc,
  output logic      host_oe,
  output logic      host_bit
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    mdc      = 1'b0;
    host_oe  = 1'b0;
    host_bit = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // ------------------------------------------------------------
  // one whole frame; mdc stands low between frames
  // ------------------------------------------------------------
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] frame;
    frame = {32'hffffffff, ST_CODE, op, phy, rg, 2'b10, wd & 16'hffef};
    rd    = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      host_oe  = (op == OP_WRITE) || (i < 46);
      host_bit = frame[63-i];
      tick(2);
      if (i >= 48) rd = {rd[14:0], mdio_wire};
      mdc = 1'b1;
      tick(2);
      mdc = 1'b0;
    end
    host_oe = 1'b0;
    tick(4);
  endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the copper control register
// assumes the design package and a pulled-up shared mdio wire
module tb_top
  import cpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic         mclk, rst_n, mdc, host_oe, host_bit, mdio_o, mdio_oe, mdio_wire;
  logic         sw_reset_req, basic_power_down, gmii_keep_alive, full_duplex;
  logic         auto_sw_reset, auto_restart_an;
  logic [7:0]   page_sel;
  logic [1:0]   strap, speed;
  logic [15:0]  rd;
  cpc_phy_ctl_t pc;
  int           num_errors, checks, cycles;

  assign mdio_wire = mdio_oe ? mdio_o : (host_oe ? host_bit : 1'b1);

  cpc_copper_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_i(mdio_wire),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .page_sel(page_sel), .sw_reset_req(sw_reset_req),
    .basic_power_down(basic_power_down), .gmii_keep_alive(gmii_keep_alive),
    .energy_sense_strap_value(strap), .speed(speed), .full_duplex(full_duplex),
    .phy_ctl(pc), .auto_sw_reset(auto_sw_reset), .auto_restart_an(auto_restart_an));

  cpc_mdio_host host_u (.mclk(mclk), .mdio_wire(mdio_wire), .mdc(mdc), .host_oe(host_oe),
    .host_bit(host_bit));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // phy core status and controls seen by the register
  task automatic core(input logic [7:0] pg, input logic [1:0] spd, input logic fd,
                      input logic ka, input logic bpd);
    page_sel = pg;
    speed = spd;
    full_duplex = fd;
    gmii_keep_alive = ka;
    basic_power_down = bpd;
  endtask

  task automatic wr(input logic [15:0] w);
    host_u.xfer(OP_WRITE, PHY_ADDR, REG_CTRL1, w, rd);
  endtask

  task automatic rdreg(input string n, input logic [15:0] e);
    host_u.xfer(OP_READ, PHY_ADDR, REG_CTRL1, 16'h0000, rd);
    chk(n, e, rd);
  endtask

  task automatic act(input string n, input logic [7:0] e);
    chk(n, {8'h00, e}, {8'h00, pc.ds_count, pc.ds_en, pc.ed_mode, pc.xover});
  endtask

  task automatic sw_reset();
    sw_reset_req = 1'b1;
    host_u.tick(1);
    sw_reset_req = 1'b0;
    host_u.tick(1);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rdreg("reset word", 16'h3260);
    act("reset active", 8'h6b);
    chk("pulse off", 16'h0000, 16'(pc.link_pulse_off));
  endtask

  task automatic t_refuse();
    host_u.xfer(OP_WRITE, 5'h02, REG_CTRL1, 16'h0008, rd);
    host_u.xfer(OP_WRITE, PHY_ADDR, 5'h11, 16'h0008, rd);
    core(8'h01, SPD_1000, 1'b0, 1'b0, 1'b0);
    wr(16'h0008);
    core(8'h00, SPD_1000, 1'b0, 1'b0, 1'b0);
    rdreg("refused", 16'h3260);
  endtask

  task automatic t_update();
    wr(16'hff8b);
    rdreg("written", 16'hff8b);
    chk("direct", 16'h000f,
      16'({pc.link_pulse_off, pc.ext_dist, pc.tx_off, pc.pol_fixed}));
    act("pending", 8'h6b);
    sw_reset();
    act("applied", 8'hfc);
    chk("pulse off", 16'h0000, 16'(pc.link_pulse_off));
    rdreg("after reset", 16'h7f8b);
    core(8'h00, SPD_10, 1'b0, 1'b0, 1'b0);
    host_u.tick(1);
    chk("force 10", 16'h0001, 16'(pc.force_link_up));
    core(8'h00, 2'h1, 1'b0, 1'b0, 1'b0);
    host_u.tick(1);
    chk("force 100", 16'h0001, 16'(pc.force_link_up));
    core(8'h00, SPD_1000, 1'b0, 1'b0, 1'b0);
    host_u.tick(1);
    chk("force 1000", 16'h0000, 16'(pc.force_link_up));
  endtask

  task automatic t_power();
    logic seen;
    core(8'h00, SPD_10, 1'b0, 1'b0, 1'b0);
    wr(16'h0024);
    chk("pd gmii jab", 16'h0007,
      16'({pc.power_down, pc.gmii_off, pc.jabber_en}));
    core(8'h00, SPD_10, 1'b1, 1'b1, 1'b0);
    host_u.tick(1);
    chk("keep alive", 16'h0004, 16'({pc.power_down, pc.gmii_off, pc.jabber_en}));
    core(8'h00, SPD_10, 1'b1, 1'b1, 1'b1);
    wr(16'h0020);
    chk("pd basic", 16'h0001, 16'(pc.power_down));
    act("held", 8'hfc);
    core(8'h00, SPD_10, 1'b1, 1'b1, 1'b0);
    seen = 1'b0;
    for (int i = 0; i < 6 && !seen; i++) begin
      host_u.tick(1);
      seen = (auto_sw_reset === 1'b1);
    end
    chk("auto reset", 16'h0001, 16'(seen));
    chk("auto an", 16'h0001, 16'(auto_restart_an));
    act("pd exit", 8'h01);
    host_u.tick(1);
    chk("auto pulse", 16'h0000, 16'(auto_sw_reset));
  endtask

  // second hardware reset in mid-run with the other strap value
  task automatic t_rereset();
    host_u.tick(1);
    rst_n = 1'b0;
    strap = 2'b11;
    host_u.tick(3);
    chk("reset oe", 16'h0000, 16'({mdio_oe, auto_sw_reset}));
    act("in reset", 8'h63);
    rst_n = 1'b1;
    host_u.tick(2);
    rdreg("rereset word", 16'h3360);
    act("rereset active", 8'h6f);
  endtask

  initial begin
    rst_n = 1'b0;
    sw_reset_req = 1'b0;
    core(8'h00, SPD_1000, 1'b0, 1'b0, 1'b0);
    strap = 2'b10;
    num_errors = 0;
    checks = 0;
    cycles = 0;
    repeat (16) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    host_u.tick(2);
    t_reset();
    t_refuse();
    t_update();
    t_power();
    t_rereset();
    wrap_up();
  end
endmodule
